/* testbench.sv */
// self-checking testbench for the vital sign message encoder
`timescale 1ns/1ps
module testbench;
   import vsme_pkg::*;
   localparam int unsigned SUMP = 240;  // shortened summary period
   localparam int unsigned INDP = 80;   // shortened indication period
   logic                     clk, arst_n, regWr, regRd, waveValid, slow;
   logic                     txValid, txReady, irq, msgDone;
   logic [3:0]               regAddr;
   logic [31:0]              regWdata, regRdata;
   logic [N_ITEMS*VAL_W-1:0] itemValue;
   logic [7:0]               txChar, msgType, msgLow, msgHigh;
   logic [11:0]              msgValue;
   int                       n_mismatch, tests_run, cyc, gaps;
   int                       cnt [256];      // messages seen per type char
   int                       lastT [256];    // cycle of latest message per type
   int                       prevT [256];    // cycle of the one before
   logic [11:0]              lastVal [256];  // latest decoded value per type
   logic [7:0]               lastLow [256];  // latest first data char per type
   logic [7:0]               lastHigh [256]; // latest second data char per type
   vsme_encoder #(.SUMMARY_PERIOD(SUMP), .INDICATION_PERIOD(INDP)) DUT (.clk(clk),
      .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .itemValue(itemValue), .waveValid(waveValid), .txChar(txChar),
      .txValid(txValid), .txReady(txReady), .irq(irq));
   vsme_host_model host (.clk(clk), .arst_n(arst_n), .txChar(txChar), .txValid(txValid),
      .slow(slow), .txReady(txReady), .msgDone(msgDone), .msgType(msgType), .msgLow(msgLow),
      .msgHigh(msgHigh), .msgValue(msgValue), .gaps(gaps));
   always #12.5 clk = ~clk;
   // log every finished message by its type char
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (msgDone === 1'b1) begin
         cnt[msgType] <= cnt[msgType] + 1;
         prevT[msgType] <= lastT[msgType];
         lastT[msgType] <= cyc;
         lastVal[msgType] <= msgValue;
         lastLow[msgType] <= msgLow;
         lastHigh[msgType] <= msgHigh;
      end
   end
   // hang guard
   always @(posedge clk) begin
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   function automatic logic [11:0] val(input int i);
      return 12'((i * 331) ^ 4035);
   endfunction : val
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   task automatic waitcnt(input int t, input int n);
      int s;
      s = cnt[t];
      repeat (3000) begin
         if (cnt[t] >= s + n) break;
         @(posedge clk);
      end
   endtask : waitcnt
   task automatic pulse;
      @(posedge clk);
      waveValid <= 1'b1;
      @(posedge clk);
      waveValid <= 1'b0;
   endtask : pulse
   // reset values, unmapped address
   task automatic t_reset;
      logic [31:0] d;
      rd(REG_CTRL, d);
      check(d, 32'h0);
      rd(REG_OPTEN, d);
      check(d, 32'h0);
      rd(REG_SEQ, d);
      check(d, 32'h0);
      wr(4'h5, 32'hffffffff);
      rd(4'h5, d);
      check(d, 32'h0);
      rd(REG_CODE, d);
      check(d, 32'h44434241);
   endtask : t_reset
   // summary period and indications per summary period
   task automatic t_timing;
      int i0;
      waitcnt(8'h44, 1);
      i0 = cnt[8'h50];
      waitcnt(8'h44, 1);
      check(32'(lastT[8'h44] - prevT[8'h44]), SUMP);
      check(32'(cnt[8'h50] - i0), SUMP / INDP);
      check(cnt[8'h42], 0);
   endtask : t_timing
   // character coding of summary and indication values, host stalling
   task automatic t_values;
      int ids [10] = '{3, 6, 8, 9, 10, 15, 16, 17, 18, 19};
      logic [11:0] v;
      slow <= 1'b1;
      waitcnt(8'h44, 1);
      waitcnt(8'h54, 1);
      foreach (ids[j]) begin
         v = val(ids[j]);
         check(lastVal[8'h41 + ids[j]], v);
         check(lastLow[8'h41 + ids[j]], 8'(v[5:0]) + 8'h20);
         check(lastHigh[8'h41 + ids[j]], 8'(v[11:6]) + 8'h20);
      end
      slow <= 1'b0;
   endtask : t_values
   // optional item enabled under a reprogrammed type char
   task automatic t_optional;
      wr(REG_CODE, 32'h44437a41);
      wr(REG_OPTEN, 32'h2);
      waitcnt(8'h7a, 1);
      check(lastVal[8'h7a], val(1));
      check(cnt[8'h42], 0);
      wr(REG_OPTEN, 32'h0);
   endtask : t_optional
   // waveform traffic, sequence in cardiac channels, wrap interrupt
   task automatic t_wave;
      logic [31:0] d;
      logic [11:0] v1, v2;
      logic [3:0]  k4;
      int c0;
      v1 = val(20);
      v2 = val(21);
      wr(REG_MASK, 32'h4);
      pulse();
      repeat (100) @(posedge clk);
      check(cnt[8'h55], 0);
      wr(REG_CTRL, 32'h1);
      c0 = cnt[8'h5c];
      for (int k = 0; k < 17; k++) begin
         k4 = 4'(k);
         pulse();
         waitcnt(8'h5d, 1);
         check(lastVal[8'h55], {k4[1:0], v1[9:0]});
         check(lastVal[8'h56], {k4[3:2], v2[9:0]});
         rd(REG_SEQ, d);
         check(d, 32'((k + 1) % 16));
         if (k == 15) begin
            check(irq, 1'b1);
            rd(REG_STATUS, d);
            check(d[EV_SEQWRAP], 1'b1);
            check(d[EV_SUMMARY], 1'b1);
            check(d[EV_INDIC], 1'b1);
            @(posedge clk);
            #1 check(irq, 1'b0);
         end
      end
      check(32'(cnt[8'h5c] - c0), 17);
      check(gaps, 0);
   endtask : t_wave
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // reset, then each scenario in turn
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {regAddr, regWdata, regWr, regRd, waveValid, slow} = '0;
      for (int i = 0; i < N_ITEMS; i++) begin
         itemValue[i*VAL_W +: VAL_W] = val(i);
      end
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_timing();
      t_values();
      t_optional();
      t_wave();
      results();
   end
endmodule : testbench

/* vsme_char_encode.sv */
// splits a 12-bit value into two printable data characters
`timescale 1ns/1ps
module vsme_char_encode (
   input  wire logic [vsme_pkg::VAL_W-1:0]  value,    // value to carry
   output logic      [vsme_pkg::CHAR_W-1:0] charLow,  // first data character
   output logic      [vsme_pkg::CHAR_W-1:0] charHigh  // second data character
);
   import vsme_pkg::*;
   // low six bits plus bias, then high six bits plus bias
   assign charLow  = {2'b00, value[HALF_W-1:0]} + CHAR_BIAS;
   assign charHigh = {2'b00, value[VAL_W-1:HALF_W]} + CHAR_BIAS;
endmodule : vsme_char_encode

/* vsme_encoder.sv */
// message encoder: schedules summary, indication and waveform messages
//
// Behaviour
// - full summary set every 15 seconds
// - indication messages every 5 seconds
// - optional summary items only when enabled
// - full disclosure adds raw waveform messages
// - keep 4-bit sequence in cardiac waveforms
// - sequence low bits in channel one top
// - sequence high bits in channel two top
// - bump sequence after both channels, wrap 16
// - every message is exactly three characters
// - carried values are at most 12 bits
// - first data char is low six plus 32
// - second data char is high six plus 32
// - messages leave as a serial character stream
`timescale 1ns/1ps
module vsme_encoder #(
   parameter int unsigned SUMMARY_PERIOD    = vsme_pkg::SUMMARY_CYCLES,    // summary period
   parameter int unsigned INDICATION_PERIOD = vsme_pkg::INDICATION_CYCLES  // indication period
) (
   input  wire logic                        clk,          // system clock
   input  wire logic                        arst_n,       // async reset, active low
   // register port
   input  wire logic [3:0]                  regAddr,      // word address
   input  wire logic [31:0]                 regWdata,     // write data
   input  wire logic                        regWr,        // write strobe
   input  wire logic                        regRd,        // read strobe
   output logic      [31:0]                 regRdata,     // read data, cycle after strobe
   // measurement values, one per item slot
   input  wire logic [vsme_pkg::N_ITEMS*vsme_pkg::VAL_W-1:0] itemValue, // latest values
   input  wire logic                        waveValid,    // new waveform sample set
   // character stream
   output logic      [vsme_pkg::CHAR_W-1:0] txChar,       // character to send
   output logic                             txValid,      // character is valid
   input  wire logic                        txReady,      // link accepts character
   output logic                             irq           // level interrupt
);
   import vsme_pkg::*;

   // whole module state
   typedef struct packed {
      vsme_state_t                 state;       // message phase
      logic [IDX_W-1:0]            idx;         // item being sent
      logic [N_ITEMS-1:0]          pend;        // items waiting to go
      logic [VAL_W-1:0]            value;       // latched value for current item
      logic [SEQ_W-1:0]            seq;         // waveform sequence counter
      logic [CHAR_W-1:0]           txChar;      // output character
      logic                        txValid;     // output valid
      logic                        fullDisc;    // full disclosure enable
      logic [SUM_LAST:0]           optEn;       // optional item enables
      logic [EV_W-1:0]             status;      // sticky events
      logic [EV_W-1:0]             mask;        // interrupt mask
      logic [N_ITEMS*CHAR_W-1:0]   code;        // type character per item
      logic [31:0]                 rdata;       // read data
      logic                        irq;         // interrupt output
   } vsme_enc_t;

   vsme_enc_t cur;                // registered state
   vsme_enc_t next_cur;           // next state

   logic              sumTick;    // summary period pulse
   logic              indTick;    // indication period pulse
   logic [CHAR_W-1:0] charLow;    // encoded first data char
   logic [CHAR_W-1:0] charHigh;   // encoded second data char
   logic [VAL_W-1:0]  itemSel;    // value of selected item, sequence bits on top for cardiac channels
   logic [IDX_W-1:0]  pickIdx;    // lowest pending item
   logic              pickAny;    // any item pending
   logic [N_ITEMS-1:0] sumMask;   // summary items to queue
   logic [N_ITEMS-1:0] indMask;   // indication items to queue
   logic [N_ITEMS-1:0] wavMask;   // waveform items to queue
   logic [EV_W-1:0]   events;     // events this cycle

   // period timers
   vsme_period_tick #(.PERIOD(SUMMARY_PERIOD)) uSumTick (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (sumTick)
   );
   vsme_period_tick #(.PERIOD(INDICATION_PERIOD)) uIndTick (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (indTick)
   );

   // two printable data characters from the latched value
   vsme_char_encode uEnc (
      .value    (cur.value),
      .charLow  (charLow),
      .charHigh (charHigh)
   );

   // item group masks
   always_comb begin
      sumMask = '0;
      indMask = '0;
      wavMask = '0;
      for (int i = 0; i < N_ITEMS; i++) begin
         if (i >= SUM_FIRST && i <= SUM_LAST) begin
            sumMask[i] = SUM_ALWAYS[i] | cur.optEn[i];
         end
         if (i >= IND_FIRST && i <= IND_LAST) begin
            indMask[i] = 1'b1;
         end
         if (i >= WAV_FIRST && i <= WAV_LAST) begin
            wavMask[i] = 1'b1;
         end
      end
   end

   // lowest pending item wins
   always_comb begin
      pickIdx = '0;
      pickAny = 1'b0;
      for (int i = N_ITEMS - 1; i >= 0; i--) begin
         if (cur.pend[i]) begin
            pickIdx = IDX_W'(i);
            pickAny = 1'b1;
         end
      end
   end

   // select value and embed sequence in cardiac channels
   always_comb begin
      itemSel = itemValue[pickIdx*VAL_W +: VAL_W];
      if (pickIdx == IDX_W'(IDX_CARD1)) begin
         itemSel[VAL_W-1 -: 2] = cur.seq[1:0];
      end else if (pickIdx == IDX_W'(IDX_CARD2)) begin
         itemSel[VAL_W-1 -: 2] = cur.seq[SEQ_W-1 -: 2];
      end
   end

   // next state
   always_comb begin
      next_cur = cur;
      events = '0;
      next_cur.rdata = '0;
      // queue new work
      if (sumTick) begin
         next_cur.pend = next_cur.pend | sumMask;
      end
      if (indTick) begin
         next_cur.pend = next_cur.pend | indMask;
      end
      if (waveValid && cur.fullDisc) begin
         next_cur.pend = next_cur.pend | wavMask;
      end
      // character stream sequencing
      unique case (cur.state)
         VSME_IDLE: begin
            if (pickAny) begin
               next_cur.idx     = pickIdx;
               next_cur.value   = itemSel;
               next_cur.pend[pickIdx] = 1'b0;
               next_cur.txChar  = cur.code[pickIdx*CHAR_W +: CHAR_W];
               next_cur.txValid = 1'b1;
               next_cur.state   = VSME_TYPE;
            end
         end
         VSME_TYPE: begin
            if (txReady) begin
               next_cur.txChar = charLow;
               next_cur.state  = VSME_LOW;
            end
         end
         VSME_LOW: begin
            if (txReady) begin
               next_cur.txChar = charHigh;
               next_cur.state  = VSME_HIGH;
            end
         end
         VSME_HIGH: begin
            if (txReady) begin
               next_cur.txValid = 1'b0;
               next_cur.state   = VSME_IDLE;
               // sequence steps once channel two closes the pair
               if (cur.idx == IDX_W'(IDX_CARD2)) begin
                  next_cur.seq = cur.seq + 4'h1;
                  if (cur.seq == '1) begin
                     events[EV_SEQWRAP] = 1'b1;
                  end
               end
               // burst done once its last queued item leaves, whichever items are enabled
               if (cur.idx <= IDX_W'(SUM_LAST) && !(|cur.pend[SUM_LAST:SUM_FIRST])) begin
                  events[EV_SUMMARY] = 1'b1;
               end
               if (cur.idx >= IDX_W'(IND_FIRST) && cur.idx <= IDX_W'(IND_LAST)
                   && !(|cur.pend[IND_LAST:IND_FIRST])) begin
                  events[EV_INDIC] = 1'b1;
               end
            end
         end
      endcase
      // register writes
      if (regWr) begin
         if (regAddr == REG_CTRL) begin
            next_cur.fullDisc = regWdata[CTRL_FULL];
         end else if (regAddr == REG_OPTEN) begin
            next_cur.optEn = regWdata[SUM_LAST:0];
         end else if (regAddr == REG_MASK) begin
            next_cur.mask = regWdata[EV_W-1:0];
         end else if (regAddr >= REG_CODE) begin
            // four type characters per code word
            for (int b = 0; b < 4; b++) begin
               next_cur.code[((int'(regAddr - REG_CODE))*4 + b)*CHAR_W +: CHAR_W] =
                  regWdata[b*CHAR_W +: CHAR_W];
            end
         end
      end
      // register reads, status cleared by read
      if (regRd) begin
         if (regAddr == REG_CTRL) begin
            next_cur.rdata[CTRL_FULL] = cur.fullDisc;
         end else if (regAddr == REG_OPTEN) begin
            next_cur.rdata[SUM_LAST:0] = cur.optEn;
         end else if (regAddr == REG_STATUS) begin
            next_cur.rdata[EV_W-1:0] = cur.status;
            next_cur.status = '0;
         end else if (regAddr == REG_MASK) begin
            next_cur.rdata[EV_W-1:0] = cur.mask;
         end else if (regAddr == REG_SEQ) begin
            next_cur.rdata[SEQ_W-1:0] = cur.seq;
         end else if (regAddr >= REG_CODE) begin
            next_cur.rdata = cur.code[(int'(regAddr - REG_CODE))*32 +: 32];
         end
      end
      // set wins over read clear
      next_cur.status = next_cur.status | events;
      next_cur.irq = |(next_cur.status & next_cur.mask);
   end

   // state register, type codes reset to distinct printable characters counting up from A
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur       <= '0;
         cur.optEn <= OPTEN_RESET;
         for (int i = 0; i < N_ITEMS; i++) begin
            cur.code[i*CHAR_W +: CHAR_W] <= 8'h41 + 8'(i);
         end
      end else begin
         cur <= next_cur;
      end
   end

   assign txChar   = cur.txChar;
   assign txValid  = cur.txValid;
   assign regRdata = cur.rdata;
   assign irq      = cur.irq;

   // data characters are always printable
   chk_data_printable : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.state inside {VSME_LOW, VSME_HIGH}) |-> cur.txChar >= CHAR_BIAS)
      else $error("data character below printable range");
   // a message is three accepted characters
   chk_msg_three : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.state == VSME_TYPE && txReady) ##1 (cur.state == VSME_LOW && txReady)
      |=> cur.state == VSME_HIGH)
      else $error("message not three characters");
   // sequence steps only after channel two
   chk_seq_step : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.seq != $past(cur.seq)) |-> ($past(cur.idx) == IDX_W'(IDX_CARD2)))
      else $error("sequence moved outside channel two");
   // channel one carries low sequence bits
   chk_card_one : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.state == VSME_TYPE && cur.idx == IDX_W'(IDX_CARD1))
      |-> cur.value[VAL_W-1 -: 2] == cur.seq[1:0])
      else $error("channel one sequence bits wrong");
   // channel two carries high sequence bits
   chk_card_two : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.state == VSME_TYPE && cur.idx == IDX_W'(IDX_CARD2))
      |-> cur.value[VAL_W-1 -: 2] == cur.seq[3:2])
      else $error("channel two sequence bits wrong");
   // second data character carries the high six bits
   chk_high_char : assert property (@(posedge clk) disable iff (!arst_n)
      (cur.state == VSME_LOW && txReady)
      |=> cur.txChar == {2'b00, cur.value[VAL_W-1:HALF_W]} + CHAR_BIAS)
      else $error("second data character wrong");
   // waveforms queue only in full disclosure
   chk_wave_gate : assert property (@(posedge clk) disable iff (!arst_n)
      (waveValid && !cur.fullDisc && cur.pend[IDX_CARD1] == 1'b0)
      |=> !cur.pend[IDX_CARD1])
      else $error("waveform queued without full disclosure");
   // disabled optional item 0 never queues
   chk_opt_gate : assert property (@(posedge clk) disable iff (!arst_n)
      (sumTick && !cur.optEn[0] && !cur.pend[0] && !(regWr && regAddr == REG_OPTEN))
      |=> !cur.pend[0])
      else $error("disabled summary item queued");
   // indication tick queues all indications
   chk_ind_queue : assert property (@(posedge clk) disable iff (!arst_n)
      (indTick && cur.state != VSME_IDLE) |=> &cur.pend[IND_LAST:IND_FIRST])
      else $error("indications not queued");
endmodule : vsme_encoder

/* vsme_host_model.sv */
// receiving host model: paces txReady, rebuilds and decodes three-character messages
`timescale 1ns/1ps
module vsme_host_model #(
   parameter logic [7:0] CODE_ONE = 8'h55,  // type char of cardiac channel one
   parameter logic [7:0] CODE_TWO = 8'h56   // type char of cardiac channel two
) (
   input  wire logic        clk,       // system clock
   input  wire logic        arst_n,    // async reset, active low
   input  wire logic [7:0]  txChar,    // character from the encoder
   input  wire logic        txValid,   // character offered
   input  wire logic        slow,      // stall three cycles in four
   output logic             txReady,   // host accepts a character
   output logic             msgDone,   // one cycle, message complete
   output logic [7:0]       msgType,   // type character
   output logic [7:0]       msgLow,    // first data character
   output logic [7:0]       msgHigh,   // second data character
   output logic [11:0]      msgValue,  // rebuilt value
   output int               gaps       // sequence jumps seen
);
   logic [1:0] pos;      // position inside the message
   logic [1:0] pace;     // stall pacing counter
   logic [1:0] seqLow;   // low sequence bits from channel one
   logic [4:0] lastSeq;  // bit4 marks a sequence seen
   logic [7:0] hb;       // second data char less the bias
   assign txReady = !slow || pace == 2'd0;
   assign hb = txChar - 8'h20;
   // accept characters, split them into type and two data characters
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos <= 2'd0;
         pace <= 2'd0;
         msgDone <= 1'b0;
         msgType <= 8'h00;
         msgLow <= 8'h00;
         msgHigh <= 8'h00;
         msgValue <= 12'h000;
         seqLow <= 2'd0;
         lastSeq <= 5'd0;
         gaps <= 0;
      end else begin
         msgDone <= 1'b0;
         pace <= pace + 2'd1;
         if (txValid && txReady) begin
            case (pos)
               2'd0: begin // type first
                  msgType <= txChar;
                  pos <= 2'd1;
               end
               2'd1: begin // low six bits next
                  msgLow <= txChar;
                  pos <= 2'd2;
               end
               default: begin // last char closes the message
                  msgHigh <= txChar;
                  pos <= 2'd0;
                  msgDone <= 1'b1;
                  msgValue <= {hb[5:0], 6'(msgLow - 8'h20)};
                  if (msgType == CODE_ONE) begin
                     seqLow <= hb[5:4];
                  end
                  if (msgType == CODE_TWO) begin // jump means lost samples
                     if (lastSeq[4] && {hb[5:4], seqLow} != lastSeq[3:0] + 4'd1) begin
                        gaps <= gaps + 1;
                     end
                     lastSeq <= {1'b1, hb[5:4], seqLow};
                  end
               end
            endcase
         end
      end
   end
endmodule : vsme_host_model

/* vsme_period_tick.sv */
// free running period counter that pulses once per period
`timescale 1ns/1ps
module vsme_period_tick #(
   parameter int unsigned PERIOD = 200
) (
   input  wire logic clk,     // system clock
   input  wire logic arst_n,  // async reset, active low
   output logic      tick     // one cycle pulse per period
);
   import vsme_pkg::*;
   typedef struct packed {
      logic [31:0] count;    // cycles elapsed
      logic        tick;     // registered pulse
   } vsme_tick_t;
   vsme_tick_t cur;           // current state
   vsme_tick_t next_cur;      // next state
   // count up and pulse on wrap
   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      if (cur.count == PERIOD - 1) begin
         next_cur.count = '0;
         next_cur.tick  = 1'b1;
      end else begin
         next_cur.count = cur.count + 32'h1;
      end
   end
   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
   assign tick = cur.tick;
endmodule : vsme_period_tick

/* vsme_pkg.sv */
// shared constants and types for the vital sign message encoder
package vsme_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 40_000_000;          // system clock rate
   localparam int unsigned SUMMARY_SEC     = 15;                  // summary period in seconds
   localparam int unsigned INDICATION_SEC  = 5;                   // indication period in seconds
   localparam int unsigned SUMMARY_CYCLES  = SUMMARY_SEC * CLK_HZ;     // summary period in cycles
   localparam int unsigned INDICATION_CYCLES = INDICATION_SEC * CLK_HZ; // indication period cycles
   // message layout
   localparam int VAL_W      = 12;                                // widest carried value
   localparam int HALF_W     = 6;                                 // bits per data character
   localparam int CHAR_W     = 8;                                 // character width
   localparam int SEQ_W      = 4;                                 // sequence counter width
   localparam int MSG_CHARS  = 3;                                 // characters per message
   localparam logic [7:0] CHAR_BIAS = 8'h20;                      // printable offset
   // item indexes
   localparam int N_ITEMS    = 32;                                // item slots
   localparam int IDX_W      = 5;                                 // item index width
   localparam int SUM_FIRST  = 0;                                 // summary items 0..14
   localparam int SUM_LAST   = 14;
   localparam int IND_FIRST  = 15;                                // indication items 15..19
   localparam int IND_LAST   = 19;
   localparam int WAV_FIRST  = 20;                                // waveform items 20..28
   localparam int WAV_LAST   = 28;
   localparam int IDX_CARD1  = 20;                                // cardiac channel one
   localparam int IDX_CARD2  = 21;                                // cardiac channel two
   // summary items always sent regardless of configuration
   localparam logic [14:0] SUM_ALWAYS = 15'h0748;                 // resp conf, temp, orient, motion, hr conf
   // register map
   localparam logic [3:0] REG_CTRL    = 4'h0;                     // bit0 full disclosure
   localparam logic [3:0] REG_OPTEN   = 4'h1;                     // optional summary enables
   localparam logic [3:0] REG_STATUS  = 4'h2;                     // sticky events, read clears
   localparam logic [3:0] REG_MASK    = 4'h3;                     // interrupt mask
   localparam logic [3:0] REG_SEQ     = 4'h4;                     // current sequence count
   localparam logic [3:0] REG_CODE    = 4'h8;                     // type code window base
   localparam int CTRL_FULL   = 0;                                // full disclosure bit
   localparam int EV_SUMMARY  = 0;                                // summary burst done
   localparam int EV_INDIC    = 1;                                // indication burst done
   localparam int EV_SEQWRAP  = 2;                                // sequence wrapped
   localparam int EV_W        = 3;                                // event bits
   localparam logic [14:0] OPTEN_RESET = 15'h0000;                // optional items off
   typedef enum logic [1:0] {
      VSME_IDLE = 2'b00,
      VSME_TYPE = 2'b01,
      VSME_LOW  = 2'b10,
      VSME_HIGH = 2'b11
   } vsme_state_t;
endpackage : vsme_pkg
